// ---- hw/isb_params.svh ----
// Constants for the implementation-specific instruction behaviour block.
`ifndef ISB_PARAMS_SVH
`define ISB_PARAMS_SVH
`define ISB_NUM_WINDOWS        8
`define ISB_WIN_BITS           3
`define ISB_PF_L2_LO0          5'h00
`define ISB_PF_L2_HI0          5'h03
`define ISB_PF_NOP_PAGE        5'h04
`define ISB_PF_ILL_LO          5'h05
`define ISB_PF_ILL_HI          5'h0F
`define ISB_PF_L2_LO1          5'h10
`define ISB_PF_L2_HI1          5'h17
`define ISB_PF_INVAL           5'h18
`define ISB_MS_HI_ZERO_LSB     33
`define ISB_MS_CARRY_BIT       32
`define ISB_KSPACE_BE          8'h04
`define ISB_KSPACE_LE          8'h0C
`endif

// ---- hw/isb_pkg.sv ----
// Types for the implementation-specific instruction behaviour block.
package isb_pkg;
   typedef enum logic [2:0] {
      ISB_PF_NONE,
      ISB_PF_L2,
      ISB_PF_NOP,
      ISB_PF_ILLEGAL,
      ISB_PF_L2_INVAL
   } isb_pf_act_t;
   typedef enum logic [1:0] {
      ISB_WIN_IDLE,
      ISB_WIN_BUSY
   } isb_win_state_t;
endpackage

// ---- hw/isb_pf_decode.sv ----
// Prefetch function code decoder.
`timescale 1ns/1ns
`include "isb_params.svh"
module isb_pf_decode (
   input  wire logic [4:0]          fcn_i,
   input  wire logic                alt_i,
   input  wire logic                hpriv_i,
   output isb_pkg::isb_pf_act_t     act_o
);
   import isb_pkg::*;
   always_comb begin
      act_o = ISB_PF_NOP;
      if (fcn_i <= `ISB_PF_L2_HI0) begin
         act_o = ISB_PF_L2;
      end else if (fcn_i == `ISB_PF_NOP_PAGE) begin
         act_o = ISB_PF_NOP;
      end else if (fcn_i <= `ISB_PF_ILL_HI) begin
         act_o = ISB_PF_ILLEGAL;
      end else if (fcn_i <= `ISB_PF_L2_HI1) begin
         act_o = ISB_PF_L2;
      end else if (fcn_i == `ISB_PF_INVAL) begin
         // Only the plain form in hyperprivileged mode touches the cache.
         act_o = (!alt_i && hpriv_i) ? ISB_PF_L2_INVAL
                                     : ISB_PF_NOP;
      end
   end
endmodule // isb_pf_decode

// ---- hw/isb_mulstep.sv ----
// Multiply-step result shaping and extended flags.
`timescale 1ns/1ns
`include "isb_params.svh"
module isb_mulstep (
   input  wire logic [31:0] low_i,
   input  wire logic        icc_c_i,
   output logic [63:0]      rd_o,
   output logic [3:0]       xcc_o
);
   always_comb begin
      rd_o = {31'h00000000, icc_c_i, low_i};
      xcc_o = {1'b0, (rd_o == 64'h0), 1'b0, 1'b0};
   end
endmodule // isb_mulstep

// ---- hw/isb_core.sv ----
// Trap decisions and state shaping for the core's implementation details.
`timescale 1ns/1ns
`include "isb_params.svh"
// Function
// - Integer register file has eight 64-bit windows per strand.
// - Window counters keep three bits; upper two read bits are zero.
// - Save with a saveable window but no clean window raises a clean-window trap.
// - Multiply-step extended flags: n,v,c zero; z when result is zero.
// - Multiply-step result bits 63:33 zero, bit 32 holds carry.
// - Unhandled subnormals trap unless the nonstandard bit flushes to zero.
// - FP exceptions are precise; underflow judged before rounding.
// - All quad-precision FP operations raise illegal instruction.
// - FP dirty flags set only on successful completion of updates.
// - Queue-not-empty reads zero; reading the queue is illegal.
// - Never raise unimplemented, sequence, hardware or register FP traps.
// - Flush ignores its address and never raises translation traps.
// - Prefetches are weak; translation misses drop them silently.
// - Listed strong and weak prefetch codes prefetch weakly into L2.
// - Codes 5 to F trap illegal; 4 and 19 to 1F are no-ops.
// - Code 18 invalidates an L2 line only in hyperprivileged plain form.
// - Double FP access word aligned but not doubleword aligned traps.
// - Quad FP loads and stores raise illegal instruction.
// - Above trap level zero, fetch and data use kernel spaces.
// - Integer multiply, step and divide execute without emulation traps.
// - Memory ordering is total store order except block operations.
module isb_core #(
   parameter int NUM_WINDOWS = `ISB_NUM_WINDOWS
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        win_wr_i,
   input  wire logic [2:0]  win_sel_i,
   input  wire logic [4:0]  win_wdata_i,
   input  wire logic        save_i,
   input  wire logic        restore_i,
   input  wire logic        window_op_a_i,
   input  wire logic        window_op_b_i,
   input  wire logic        multiply_step_op_i,
   input  wire logic [31:0] ms_low_i,
   input  wire logic        ms_icc_c_i,
   input  wire logic        int_muldiv_op_i,
   input  wire logic        fp_op_i,
   input  wire logic        fp_subnormal_unhandled_i,
   input  wire logic        nonstandard_fp_bit_i,
   input  wire logic        fp_ieee_exc_i,
   input  wire logic        fp_quad_op_i,
   input  wire logic        fp_writes_upper_i,
   input  wire logic        fp_writes_lower_i,
   input  wire logic        fp_cond_met_i,
   input  wire logic        fp_complete_i,
   input  wire logic        privileged_reg_read_op_i,
   input  wire logic        rd_fp_deferred_queue_i,
   input  wire logic        flush_op_i,
   input  wire logic        prefetch_op_i,
   input  wire logic        alt_space_prefetch_op_i,
   input  wire logic [4:0]  pf_fcn_i,
   input  wire logic        hpriv_i,
   input  wire logic        xlate_miss_i,
   input  wire logic        fp_double_load_op_i,
   input  wire logic        fp_double_store_op_i,
   input  wire logic        fp_quad_load_op_i,
   input  wire logic        fp_quad_store_op_i,
   input  wire logic [2:0]  ea_low_i,
   input  wire logic        block_mem_op_i,
   input  wire logic [2:0]  trap_level_i,
   input  wire logic        current_little_endian_bit_i,
   input  wire logic [7:0]  primary_space_i,
   output logic [4:0]       current_window_pointer_o,
   output logic [4:0]       saveable_window_count_o,
   output logic [4:0]       restorable_window_count_o,
   output logic [4:0]       clean_window_count_o,
   output logic [4:0]       foreign_window_count_o,
   output logic             clean_window_trap_o,
   output logic [63:0]      ms_rd_o,
   output logic [3:0]       ms_xcc_o,
   output logic             ms_valid_o,
   output logic             illegal_instr_trap_o,
   output logic             incomplete_fp_trap_o,
   output logic             fp_flush_zero_o,
   output logic             fp_underflow_pre_round_o,
   output logic             fp_misc_exception_trap_o,
   output logic             fp_upper_dirty_o,
   output logic             fp_lower_dirty_o,
   output logic             fp_queue_not_empty_o,
   output logic             fp_ldst_misalign_trap_o,
   output logic             invalid_space_access_trap_o,
   output logic             data_translation_miss_trap_o,
   output logic             pf_l2_req_o,
   output logic             pf_l2_inval_o,
   output logic             flush_sync_o,
   output logic [7:0]       fetch_space_o,
   output logic [7:0]       data_space_o,
   output logic             relaxed_order_o,
   output logic             muldiv_exec_o
);
   import isb_pkg::*;

   localparam int WB = `ISB_WIN_BITS;

   logic [WB-1:0] cwp_reg;
   logic [WB-1:0] saveable_window_count_reg;
   logic [WB-1:0] restorable_window_count_reg;
   logic [WB-1:0] clean_window_count_reg;
   logic [WB-1:0] foreign_window_count_reg;
   logic [63:0]   ms_rd;
   logic [3:0]    ms_xcc;
   isb_pf_act_t   pf_act;
   logic          save_ok;
   logic          fp_quad_any;
   logic          pf_illegal;

   isb_mulstep u_mulstep (
      .low_i   (ms_low_i),
      .icc_c_i (ms_icc_c_i),
      .rd_o    (ms_rd),
      .xcc_o   (ms_xcc)
   );

   isb_pf_decode u_pf_decode (
      .fcn_i   (pf_fcn_i),
      .alt_i   (alt_space_prefetch_op_i),
      .hpriv_i (hpriv_i),
      .act_o   (pf_act)
   );

   // A save needs both a saveable window and a clean one.
   assign save_ok = save_i && (saveable_window_count_reg != '0) && (clean_window_count_reg != '0);
   assign fp_quad_any = fp_quad_op_i || fp_quad_load_op_i
                        || fp_quad_store_op_i;
   assign pf_illegal = prefetch_op_i && (pf_act == ISB_PF_ILLEGAL);

   // Window state: the register file has NUM_WINDOWS windows, so the
   // pointer wraps modulo three bits.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cwp_reg        <= '0;
         saveable_window_count_reg    <= 3'h6;
         restorable_window_count_reg <= '0;
         clean_window_count_reg   <= 3'h7;
         foreign_window_count_reg   <= '0;
      end else if (win_wr_i) begin
         case (win_sel_i)
            3'h0: cwp_reg <= win_wdata_i[WB-1:0];
            3'h1: saveable_window_count_reg <= win_wdata_i[WB-1:0];
            3'h2: restorable_window_count_reg <= win_wdata_i[WB-1:0];
            3'h3: clean_window_count_reg <= win_wdata_i[WB-1:0];
            3'h4: foreign_window_count_reg <= win_wdata_i[WB-1:0];
            default: cwp_reg <= cwp_reg;
         endcase
      end else if (save_ok) begin
         cwp_reg        <= cwp_reg + 3'h1;
         saveable_window_count_reg    <= saveable_window_count_reg - 3'h1;
         restorable_window_count_reg <= restorable_window_count_reg + 3'h1;
         clean_window_count_reg   <= clean_window_count_reg - 3'h1;
      end else if (restore_i && restorable_window_count_reg != '0) begin
         cwp_reg        <= cwp_reg - 3'h1;
         saveable_window_count_reg    <= saveable_window_count_reg + 3'h1;
         restorable_window_count_reg <= restorable_window_count_reg - 3'h1;
      end else if (window_op_a_i) begin
         saveable_window_count_reg    <= saveable_window_count_reg + 3'h1;
         if (foreign_window_count_reg != '0) begin
            foreign_window_count_reg <= foreign_window_count_reg - 3'h1;
         end else begin
            restorable_window_count_reg <= restorable_window_count_reg - 3'h1;
         end
      end else if (window_op_b_i) begin
         restorable_window_count_reg <= restorable_window_count_reg + 3'h1;
         if (clean_window_count_reg != 3'h7) begin
            clean_window_count_reg <= clean_window_count_reg + 3'h1;
         end
         if (foreign_window_count_reg != '0) begin
            foreign_window_count_reg <= foreign_window_count_reg - 3'h1;
         end else begin
            saveable_window_count_reg <= saveable_window_count_reg - 3'h1;
         end
      end
   end

   // Window readback and trap outputs.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         current_window_pointer_o  <= '0;
         saveable_window_count_o   <= '0;
         restorable_window_count_o <= '0;
         clean_window_count_o      <= '0;
         foreign_window_count_o    <= '0;
         clean_window_trap_o       <= 1'b0;
      end else begin
         current_window_pointer_o  <= {2'b00, cwp_reg};
         saveable_window_count_o   <= {2'b00, saveable_window_count_reg};
         restorable_window_count_o <= {2'b00, restorable_window_count_reg};
         clean_window_count_o      <= {2'b00, clean_window_count_reg};
         foreign_window_count_o    <= {2'b00, foreign_window_count_reg};
         clean_window_trap_o <= save_i && (saveable_window_count_reg != '0)
                                && (clean_window_count_reg == '0);
      end
   end

   // Integer multiply-step and multiply/divide execution.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ms_rd_o       <= '0;
         ms_xcc_o      <= '0;
         ms_valid_o    <= 1'b0;
         muldiv_exec_o <= 1'b0;
      end else begin
         ms_valid_o    <= multiply_step_op_i;
         // Multiply and divide never trap for emulation here.
         muldiv_exec_o <= int_muldiv_op_i || multiply_step_op_i;
         if (multiply_step_op_i) begin
            ms_rd_o  <= ms_rd;
            ms_xcc_o <= ms_xcc;
         end
      end
   end

   // Floating-point trap decisions, all taken in issue order so they
   // stay precise.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         incomplete_fp_trap_o     <= 1'b0;
         fp_flush_zero_o          <= 1'b0;
         fp_underflow_pre_round_o <= 1'b0;
         fp_misc_exception_trap_o <= 1'b0;
         fp_queue_not_empty_o     <= 1'b0;
      end else begin
         incomplete_fp_trap_o <= fp_op_i && fp_subnormal_unhandled_i
                                 && !nonstandard_fp_bit_i;
         fp_flush_zero_o <= fp_op_i && fp_subnormal_unhandled_i
                            && nonstandard_fp_bit_i;
         // The unit flags underflow from the unrounded value.
         fp_underflow_pre_round_o <= fp_op_i && fp_ieee_exc_i;
         // Only the incomplete-operation type is ever raised.
         fp_misc_exception_trap_o <= fp_op_i && fp_subnormal_unhandled_i
                                     && !nonstandard_fp_bit_i;
         fp_queue_not_empty_o <= 1'b0;
      end
   end

   // Illegal-instruction collection.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         illegal_instr_trap_o <= 1'b0;
      end else begin
         illegal_instr_trap_o <= fp_quad_op_i
            || fp_quad_load_op_i || fp_quad_store_op_i
            || (privileged_reg_read_op_i && rd_fp_deferred_queue_i)
            || pf_illegal;
      end
   end

   // Dirty flags are sticky and change only on a clean completion.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fp_upper_dirty_o <= 1'b0;
         fp_lower_dirty_o <= 1'b0;
      end else if (fp_complete_i && fp_cond_met_i && !fp_quad_any
                   && !(fp_subnormal_unhandled_i && !nonstandard_fp_bit_i)
                   && !fp_ieee_exc_i) begin
         if (fp_writes_upper_i) begin
            fp_upper_dirty_o <= 1'b1;
         end
         if (fp_writes_lower_i) begin
            fp_lower_dirty_o <= 1'b1;
         end
      end
   end

   // Memory operations: alignment, flush, prefetch.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fp_ldst_misalign_trap_o      <= 1'b0;
         invalid_space_access_trap_o  <= 1'b0;
         data_translation_miss_trap_o <= 1'b0;
         pf_l2_req_o                  <= 1'b0;
         pf_l2_inval_o                <= 1'b0;
         flush_sync_o                 <= 1'b0;
      end else begin
         fp_ldst_misalign_trap_o <= (fp_double_load_op_i
            || fp_double_store_op_i)
            && (ea_low_i[1:0] == 2'b00) && ea_low_i[2];
         // Flush and prefetch never report translation faults.
         invalid_space_access_trap_o  <= 1'b0;
         data_translation_miss_trap_o <= xlate_miss_i && !flush_op_i
            && !prefetch_op_i && !fp_quad_any;
         pf_l2_req_o <= prefetch_op_i && !xlate_miss_i
            && (pf_act == ISB_PF_L2);
         pf_l2_inval_o <= prefetch_op_i && !xlate_miss_i
            && (pf_act == ISB_PF_L2_INVAL);
         flush_sync_o <= flush_op_i;
      end
   end

   // Implicit address spaces and ordering model.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fetch_space_o   <= `ISB_KSPACE_BE;
         data_space_o    <= `ISB_KSPACE_BE;
         relaxed_order_o <= 1'b0;
      end else begin
         if (trap_level_i != 3'h0) begin
            fetch_space_o <= `ISB_KSPACE_BE;
            data_space_o  <= current_little_endian_bit_i ?
                             `ISB_KSPACE_LE : `ISB_KSPACE_BE;
         end else begin
            fetch_space_o <= primary_space_i;
            data_space_o  <= primary_space_i;
         end
         relaxed_order_o <= block_mem_op_i;
      end
   end

   default clocking isb_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);
   clean_trap_a: assert property (
      (save_i && saveable_window_count_reg != '0 && clean_window_count_reg == '0)
      |=> clean_window_trap_o)
      else $error("clean window trap missing");
   win_upper_a: assert property (
      current_window_pointer_o[4:3] == 2'b00
      && clean_window_count_o[4:3] == 2'b00)
      else $error("window counter upper bits not zero");
   ms_shape_a: assert property (
      multiply_step_op_i |=> (ms_rd_o[63:33] == '0
      && ms_rd_o[32] == $past(ms_icc_c_i)))
      else $error("multiply step result shape wrong");
   ms_flags_a: assert property (
      ms_valid_o |-> (ms_xcc_o[2] == (ms_rd_o == 64'h0)
      && ms_xcc_o[3] == 1'b0 && ms_xcc_o[1:0] == 2'b00))
      else $error("multiply step flags wrong");
   subnorm_trap_a: assert property (
      (fp_op_i && fp_subnormal_unhandled_i)
      |=> (incomplete_fp_trap_o != $past(nonstandard_fp_bit_i)))
      else $error("subnormal trap decision wrong");
   quad_ill_a: assert property (
      (fp_quad_op_i || fp_quad_load_op_i) |=> illegal_instr_trap_o)
      else $error("quad op did not trap");
   qne_zero_a: assert property (!fp_queue_not_empty_o)
      else $error("queue not empty bit set");
   dirty_hold_a: assert property (
      (!fp_cond_met_i || !fp_complete_i || fp_ieee_exc_i)
      |=> $stable(fp_upper_dirty_o) && $stable(fp_lower_dirty_o))
      else $error("dirty flag changed without completion");
   misalign_a: assert property (
      (fp_double_load_op_i && ea_low_i == 3'h4) |=> fp_ldst_misalign_trap_o)
      else $error("misaligned double access not trapped");
   pf_ill_a: assert property (
      (prefetch_op_i && pf_fcn_i >= 5'h05 && pf_fcn_i <= 5'h0F)
      |=> illegal_instr_trap_o && !pf_l2_req_o)
      else $error("illegal prefetch code not trapped");
   pf_weak_a: assert property (
      (prefetch_op_i && xlate_miss_i)
      |=> !data_translation_miss_trap_o && !pf_l2_req_o)
      else $error("prefetch miss not dropped");
   tl_space_a: assert property (
      (trap_level_i != 3'h0 && current_little_endian_bit_i)
      |=> data_space_o == `ISB_KSPACE_LE && fetch_space_o == `ISB_KSPACE_BE)
      else $error("implicit space wrong above trap level zero");
endmodule // isb_core

// ---- testbench/isb_core_tb_top.sv ----
// Self-checking bench for the instruction behaviour core.
`timescale 1ns/1ns
module isb_core_tb_top;
   import isb_pkg::*;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic win_wr_i, save_i, restore_i, window_op_a_i, window_op_b_i;
   logic multiply_step_op_i, ms_icc_c_i, int_muldiv_op_i, fp_op_i;
   logic fp_subnormal_unhandled_i, nonstandard_fp_bit_i, fp_ieee_exc_i;
   logic fp_quad_op_i, fp_writes_upper_i, fp_writes_lower_i, fp_cond_met_i;
   logic fp_complete_i, privileged_reg_read_op_i, rd_fp_deferred_queue_i;
   logic flush_op_i, prefetch_op_i, alt_space_prefetch_op_i, hpriv_i;
   logic xlate_miss_i, fp_double_load_op_i, fp_double_store_op_i;
   logic fp_quad_load_op_i, fp_quad_store_op_i, block_mem_op_i;
   logic current_little_endian_bit_i;
   logic [2:0]  win_sel_i, ea_low_i, trap_level_i;
   logic [4:0]  win_wdata_i, pf_fcn_i;
   logic [31:0] ms_low_i;
   logic [7:0]  primary_space_i, fetch_space_o, data_space_o, exp_sp;
   logic [4:0]  current_window_pointer_o, saveable_window_count_o;
   logic [4:0]  restorable_window_count_o, clean_window_count_o;
   logic [4:0]  foreign_window_count_o;
   logic [63:0] ms_rd_o;
   logic [3:0]  ms_xcc_o;
   logic clean_window_trap_o, ms_valid_o, illegal_instr_trap_o;
   logic incomplete_fp_trap_o, fp_flush_zero_o, fp_underflow_pre_round_o;
   logic fp_misc_exception_trap_o, fp_upper_dirty_o, fp_lower_dirty_o;
   logic fp_queue_not_empty_o, fp_ldst_misalign_trap_o, pf_l2_req_o;
   logic invalid_space_access_trap_o, data_translation_miss_trap_o;
   logic pf_l2_inval_o, flush_sync_o, relaxed_order_o, muldiv_exec_o;
   int   bad_count = 0;
   int   check_count = 0;

   isb_core uut (.sys_clk_i, .rstn_i, .win_wr_i, .win_sel_i, .win_wdata_i,
      .save_i, .restore_i, .window_op_a_i, .window_op_b_i,
      .multiply_step_op_i, .ms_low_i, .ms_icc_c_i, .int_muldiv_op_i,
      .fp_op_i, .fp_subnormal_unhandled_i, .nonstandard_fp_bit_i,
      .fp_ieee_exc_i, .fp_quad_op_i, .fp_writes_upper_i, .fp_writes_lower_i,
      .fp_cond_met_i, .fp_complete_i, .privileged_reg_read_op_i,
      .rd_fp_deferred_queue_i, .flush_op_i, .prefetch_op_i,
      .alt_space_prefetch_op_i, .pf_fcn_i, .hpriv_i, .xlate_miss_i,
      .fp_double_load_op_i, .fp_double_store_op_i, .fp_quad_load_op_i,
      .fp_quad_store_op_i, .ea_low_i, .block_mem_op_i, .trap_level_i,
      .current_little_endian_bit_i, .primary_space_i,
      .current_window_pointer_o, .saveable_window_count_o,
      .restorable_window_count_o, .clean_window_count_o,
      .foreign_window_count_o, .clean_window_trap_o, .ms_rd_o, .ms_xcc_o,
      .ms_valid_o, .illegal_instr_trap_o, .incomplete_fp_trap_o,
      .fp_flush_zero_o, .fp_underflow_pre_round_o, .fp_misc_exception_trap_o,
      .fp_upper_dirty_o, .fp_lower_dirty_o, .fp_queue_not_empty_o,
      .fp_ldst_misalign_trap_o, .invalid_space_access_trap_o,
      .data_translation_miss_trap_o, .pf_l2_req_o, .pf_l2_inval_o,
      .flush_sync_o, .fetch_space_o, .data_space_o, .relaxed_order_o,
      .muldiv_exec_o);

   always #25 sys_clk_i = ~sys_clk_i;

   // Every qualifier drops back to zero so each request lasts one cycle.
   task automatic idle();
      {win_wr_i, save_i, restore_i, window_op_a_i, window_op_b_i} <= 5'h00;
      {multiply_step_op_i, ms_icc_c_i, int_muldiv_op_i, fp_op_i} <= 4'h0;
      {fp_subnormal_unhandled_i, nonstandard_fp_bit_i, fp_ieee_exc_i} <= 3'h0;
      {fp_quad_op_i, fp_writes_upper_i, fp_writes_lower_i} <= 3'h0;
      {fp_cond_met_i, fp_complete_i, privileged_reg_read_op_i} <= 3'h0;
      {rd_fp_deferred_queue_i, flush_op_i, prefetch_op_i} <= 3'h0;
      {alt_space_prefetch_op_i, hpriv_i, xlate_miss_i} <= 3'h0;
      {fp_double_load_op_i, fp_double_store_op_i, block_mem_op_i} <= 3'h0;
      {fp_quad_load_op_i, fp_quad_store_op_i} <= 2'h0;
      {current_little_endian_bit_i, win_sel_i, ea_low_i} <= 7'h00;
      {trap_level_i, win_wdata_i, pf_fcn_i} <= 13'h0000;
      ms_low_i <= 32'h0000_0000;
      primary_space_i <= 8'h80;
   endtask

   // The design samples at the next edge; outputs are read just after it.
   task automatic go();
      @(posedge sys_clk_i);
      idle();
      #1;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge sys_clk_i);
      bad_count++;
      $display("ERROR watchdog exp done got hang");
      print_verdict();
   end

   initial begin
      idle();
      repeat (10) @(posedge sys_clk_i);
      `CHK("rst_space", 8'h04, fetch_space_o)
      rstn_i <= 1'b1;
      go();
      `CHK("rst_save", 5'h06, saveable_window_count_o)
      `CHK("rst_clean", 5'h07, clean_window_count_o)
      `CHK("qne", 1'b0, fp_queue_not_empty_o)
      $display("test reset done");
      // Window writes: upper two bits are dropped on every counter.
      for (int s = 0; s < 6; s++) begin
         @(posedge sys_clk_i);
         win_wr_i <= 1'b1;
         win_sel_i <= (s == 5) ? 3'h5 : 3'(s);
         win_wdata_i <= (s == 3) ? 5'h18 : {2'b11, 3'(s + 1)};
         go();
      end
      `CHK("cwp", 5'h01, current_window_pointer_o)
      `CHK("save_cnt", 5'h02, saveable_window_count_o)
      `CHK("rest_cnt", 5'h03, restorable_window_count_o)
      `CHK("clean_cnt", 5'h00, clean_window_count_o)
      `CHK("other_cnt", 5'h05, foreign_window_count_o)
      @(posedge sys_clk_i);
      save_i <= 1'b1;
      go();
      `CHK("cw_trap", 1'b1, clean_window_trap_o)
      `CHK("cw_cwp", 5'h01, current_window_pointer_o)
      // Two restores wrap the pointer below zero to seven.
      for (int r = 0; r < 2; r++) begin
         @(posedge sys_clk_i);
         restore_i <= 1'b1;
         go();
      end
      // Readback trails the window state by one more edge.
      go();
      `CHK("cw_trap_end", 1'b0, clean_window_trap_o)
      `CHK("wrap_cwp", 5'h07, current_window_pointer_o)
      `CHK("wrap_rest", 5'h01, restorable_window_count_o)
      $display("test windows done");
      for (int m = 0; m < 3; m++) begin
         @(posedge sys_clk_i);
         multiply_step_op_i <= 1'b1;
         ms_low_i <= (m == 2) ? 32'hFFFF_FFFF : 32'h0000_0000;
         ms_icc_c_i <= (m != 0);
         go();
         `CHK("ms_rd", {31'h0, m != 0, {32{m == 2}}}, ms_rd_o)
         `CHK("ms_xcc", (m == 0) ? 4'h4 : 4'h0, ms_xcc_o)
         `CHK("ms_vld", 1'b1, ms_valid_o)
      end
      $display("test multiply step done");
      for (int n = 0; n < 2; n++) begin
         @(posedge sys_clk_i);
         fp_op_i <= 1'b1;
         fp_subnormal_unhandled_i <= 1'b1;
         nonstandard_fp_bit_i <= 1'(n);
         go();
         `CHK("unfin", 1'(n == 0), incomplete_fp_trap_o)
         `CHK("ftz", 1'(n), fp_flush_zero_o)
      end
      // A trapping op and an untaken move must leave the dirty bits alone.
      @(posedge sys_clk_i);
      {fp_op_i, fp_writes_upper_i, fp_ieee_exc_i} <= 3'h7;
      go();
      `CHK("unf_pre", 1'b1, fp_underflow_pre_round_o)
      `CHK("du_trap", 1'b0, fp_upper_dirty_o)
      @(posedge sys_clk_i);
      {fp_op_i, fp_writes_lower_i, fp_complete_i} <= 3'h7;
      go();
      `CHK("dl_nocond", 1'b0, fp_lower_dirty_o)
      @(posedge sys_clk_i);
      {fp_op_i, fp_writes_lower_i, fp_complete_i, fp_cond_met_i} <= 4'hF;
      go();
      `CHK("dl_set", 1'b1, fp_lower_dirty_o)
      `CHK("du_keep", 1'b0, fp_upper_dirty_o)
      `CHK("no_misc", 1'b0, fp_misc_exception_trap_o)
      $display("test floating point done");
      // Quad op, queue read, quad load, quad store each trap as illegal.
      for (int q = 0; q < 4; q++) begin
         @(posedge sys_clk_i);
         fp_op_i <= (q == 0);
         fp_quad_op_i <= (q == 0);
         {privileged_reg_read_op_i, rd_fp_deferred_queue_i} <= {2{q == 1}};
         fp_quad_load_op_i <= (q == 2);
         fp_quad_store_op_i <= (q == 3);
         go();
         `CHK("q_ill", 1'b1, illegal_instr_trap_o)
      end
      for (int f = 0; f < 35; f++) begin
         @(posedge sys_clk_i);
         prefetch_op_i <= 1'b1;
         // Past the sweep: code 18 unprivileged, code 18 alternate, a miss.
         pf_fcn_i <= (f < 32) ? 5'(f) : ((f == 34) ? 5'h00 : 5'h18);
         hpriv_i <= (f != 32);
         alt_space_prefetch_op_i <= (f == 33);
         xlate_miss_i <= (f == 34);
         go();
         `CHK("pf_ill", 1'(f > 4 && f < 16), illegal_instr_trap_o)
         `CHK("l2", 1'(f < 4 || (f > 15 && f < 24)), pf_l2_req_o)
         `CHK("pf_inv", 1'(f == 24), pf_l2_inval_o)
         `CHK("pf_miss", 1'b0, data_translation_miss_trap_o)
      end
      $display("test prefetch done");
      @(posedge sys_clk_i);
      {flush_op_i, xlate_miss_i} <= 2'h3;
      go();
      `CHK("fl_sync", 1'b1, flush_sync_o)
      `CHK("fl_miss", 1'b0, data_translation_miss_trap_o)
      `CHK("fl_asi", 1'b0, invalid_space_access_trap_o)
      for (int a = 0; a < 3; a++) begin
         @(posedge sys_clk_i);
         fp_double_load_op_i <= (a != 2);
         fp_double_store_op_i <= (a == 2);
         ea_low_i <= (a == 1) ? 3'h0 : 3'h4;
         go();
         `CHK("misalign", 1'(a != 1), fp_ldst_misalign_trap_o)
      end
      for (int t = 0; t < 3; t++) begin
         @(posedge sys_clk_i);
         trap_level_i <= (t == 2) ? 3'h0 : 3'h1;
         current_little_endian_bit_i <= (t != 0);
         go();
         `CHK("fetch_sp", (t == 2) ? 8'h80 : 8'h04, fetch_space_o)
         exp_sp = (t == 1) ? 8'h0C : 8'h04;
         `CHK("data_sp", (t == 2) ? 8'h80 : exp_sp, data_space_o)
      end
      @(posedge sys_clk_i);
      {int_muldiv_op_i, block_mem_op_i} <= 2'h3;
      go();
      `CHK("muldiv", 1'b1, muldiv_exec_o)
      `CHK("md_ill", 1'b0, illegal_instr_trap_o)
      `CHK("rmo", 1'b1, relaxed_order_o)
      go();
      `CHK("tso", 1'b0, relaxed_order_o)
      $display("test memory done");
      print_verdict();
   end
endmodule // isb_core_tb_top
